// ---- bench/tec_pins.sv ----
// partner model: sources for the trigger and capture pins
module tec_pins (
    input  wire logic clock,
    input  wire logic fire_a,
    input  wire logic fire_b,
    output logic      trig_capture_in_a,
    output logic      capture_in_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_a = 1'b0;
    logic pin_b = 1'b0;
    // pins idle low, the level the edge detectors reset to
    assign trig_capture_in_a = pin_a;
    assign capture_in_b      = pin_b;
    // each request flips its pin just after the edge; level holds long
    always @(posedge clock) begin
        if (fire_a) pin_a <= #1 ~pin_a;
        if (fire_b) pin_b <= #1 ~pin_b;
    end
endmodule : tec_pins

// ---- bench/tec_timer_tb.sv ----
// testbench for the timer/event counter
module tec_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [1:0] m; int n; logic [15:0] c;} tec_row_t;
    logic clock = 0, rst = 1, count_tick = 0, oneshot_en = 0;
    logic [1:0]  op_mode = 0, edge_sel = tec_pkg::EDGE_BOTH;
    logic capture_mode_a = 0, capture_mode_b = 0, oneshot_sw_trigger = 0;
    logic [15:0] cmp_a_wdata = 0, cmp_b_wdata = 0;
    logic cmp_a_we = 0, cmp_b_we = 0, fire_a = 0, fire_b = 0;
    logic trig_capture_in_a, capture_in_b;
    logic [15:0] count_register, cap_cmp_reg_a, cap_cmp_reg_b;
    logic match_a_irq, match_b_irq, timer_out, oneshot_busy;
    int num_errors = 0, n_compared = 0, n_wait = 0;
    tec_row_t rows [4] = '{'{tec_pkg::MODE_STOP, 5, 16'h0000},
        '{tec_pkg::MODE_FREE, 5, 16'h0005}, '{tec_pkg::MODE_FREE, 3, 16'h0008},
        '{tec_pkg::MODE_CLR_TRG, 4, 16'h000c}};
    // clock generator, 4 ns period
    always #2 clock = ~clock;
    tec_timer u_dut (.clock, .rst, .count_tick, .op_mode, .edge_sel,
        .capture_mode_a, .capture_mode_b, .oneshot_en, .oneshot_sw_trigger,
        .cmp_a_wdata, .cmp_a_we, .cmp_b_wdata, .cmp_b_we, .trig_capture_in_a,
        .capture_in_b, .count_register, .cap_cmp_reg_a, .cap_cmp_reg_b,
        .match_a_irq, .match_b_irq, .timer_out, .oneshot_busy);
    tec_pins u_pins (.clock, .fire_a, .fire_b, .trig_capture_in_a,
        .capture_in_b);
    ////////////////////////////////////////////////////////////////////////
    // compare and tally
    task automatic chk(input string nm, input logic [63:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // verdict and end of run
    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    // bounded wait for the pulse output to reach a level; n edges waited
    task automatic wt(input logic lvl, output int n);
        n = 0;
        while (n < 300 && timer_out !== lvl) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (timer_out !== lvl) begin
            num_errors++;
            final_report();
        end
    endtask : wt
    // n count ticks, then settle
    task automatic ticks(input int n);
        @(posedge clock);
        count_tick <= 1'b1;
        repeat (n) @(posedge clock);
        count_tick <= 1'b0;
        @(posedge clock);
        #1;
    endtask : ticks
    // one-cycle pulse: 0 software trigger, 1 pin a, 2 pin b
    task automatic pulse(input int sel);
        @(posedge clock);
        if (sel == 0) oneshot_sw_trigger <= 1'b1;
        else if (sel == 1) fire_a <= 1'b1;
        else fire_b <= 1'b1;
        @(posedge clock);
        {oneshot_sw_trigger, fire_a, fire_b} <= 3'h0;
        #1;
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        #1;
        chk("reset", {count_register, cap_cmp_reg_a, cap_cmp_reg_b, match_a_irq,
            match_b_irq, timer_out, oneshot_busy}, 64'h0000_0000_0000_0000);
        @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clock);
            op_mode <= rows[i].m;
            repeat (3) @(posedge clock);
            ticks(rows[i].n);
            chk("count", count_register, rows[i].c);
        end
        @(posedge clock);
        op_mode <= tec_pkg::MODE_FREE;
        cmp_a_wdata <= 16'h0028;
        cmp_b_wdata <= 16'h0008;
        {cmp_a_we, cmp_b_we, oneshot_en, count_tick} <= 4'h0f;
        @(posedge clock);
        {cmp_a_we, cmp_b_we} <= 2'h0;
        pulse(0);
        @(posedge clock);
        #1;
        chk("busy", oneshot_busy, 1'b1);
        wt(1'b1, n_wait);
        chk("b match", {match_b_irq, count_register}, 17'h1_0009);
        pulse(1);
        wt(1'b0, n_wait);
        chk("a match", {match_a_irq, oneshot_busy, count_register},
            18'h2_0029);
        chk("a match time", n_wait, 30);
        pulse(1);
        wt(1'b1, n_wait);
        chk("pin start", {match_b_irq, count_register}, 17'h1_0009);
        chk("pin start time", n_wait, 12);
        wt(1'b0, n_wait);
        @(posedge clock);
        op_mode <= tec_pkg::MODE_CLR_CMP;
        pulse(0);
        repeat (5) @(posedge clock);
        #1;
        chk("no shot", {oneshot_busy, timer_out}, 2'h0);
        // stop, reload nonzero compares, then clear-on-match mode
        @(posedge clock);
        op_mode <= tec_pkg::MODE_STOP;
        cmp_a_wdata <= 16'h0004;
        cmp_b_wdata <= 16'h0002;
        {cmp_a_we, cmp_b_we} <= 2'h3;
        @(posedge clock);
        {cmp_a_we, cmp_b_we} <= 2'h0;
        op_mode <= tec_pkg::MODE_CLR_CMP;
        repeat (5) @(posedge clock);
        #1;
        chk("cmp clear", {match_a_irq, count_register}, 17'h1_0000);
        // both registers capture, one pin each
        @(posedge clock);
        op_mode <= tec_pkg::MODE_STOP;
        {capture_mode_a, capture_mode_b, oneshot_en} <= 3'h6;
        @(posedge clock);
        op_mode <= tec_pkg::MODE_FREE;
        pulse(1);
        repeat (3) @(posedge clock);
        #1;
        chk("capture b", cap_cmp_reg_b, 16'h0004);
        pulse(2);
        repeat (3) @(posedge clock);
        #1;
        chk("capture a", cap_cmp_reg_a, 16'h0009);
        final_report();
    end
endmodule : tec_timer_tb

// ---- hw/tec_pkg.sv ----
// package: constants for the timer/event counter
package tec_pkg;
    localparam int          CNT_W        = 16;
    localparam logic [1:0]  MODE_STOP    = 2'h0;
    localparam logic [1:0]  MODE_FREE    = 2'h1;
    localparam logic [1:0]  MODE_CLR_TRG = 2'h2;
    localparam logic [1:0]  MODE_CLR_CMP = 2'h3;
    localparam logic [1:0]  EDGE_FALL    = 2'h0;
    localparam logic [1:0]  EDGE_RISE    = 2'h1;
    localparam logic [1:0]  EDGE_NONE    = 2'h2;
    localparam logic [1:0]  EDGE_BOTH    = 2'h3;
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam logic [15:0] CNT_ONE      = 16'h0001;
    localparam logic [15:0] CMP_ZERO     = 16'h0000;
endpackage : tec_pkg

// ---- hw/tec_timer.sv ----
// timer/event counter with two capture/compare registers and one-shot
// Functional notes
// - count register holds live event count
// - external trigger stays live under software
// - mode 00 stops; nonzero starts counting
// - external trigger ignored during pulse
// - start to match may slip one tick
// - capture values held through stop
// - a match ends the one-shot pulse; b match raises the output
// - one-shot only in free or trigger-clear
module tec_timer (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        count_tick,
    input  wire logic [1:0]  op_mode,
    input  wire logic [1:0]  edge_sel,
    input  wire logic        capture_mode_a,
    input  wire logic        capture_mode_b,
    input  wire logic        oneshot_en,
    input  wire logic        oneshot_sw_trigger,
    input  wire logic [15:0] cmp_a_wdata,
    input  wire logic        cmp_a_we,
    input  wire logic [15:0] cmp_b_wdata,
    input  wire logic        cmp_b_we,
    input  wire logic        trig_capture_in_a,
    input  wire logic        capture_in_b,
    output logic      [15:0] count_register,
    output logic      [15:0] cap_cmp_reg_a,
    output logic      [15:0] cap_cmp_reg_b,
    output logic             match_a_irq,
    output logic             match_b_irq,
    output logic             timer_out,
    output logic             oneshot_busy
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic [1:0] sync_a_reg;
    logic [1:0] sync_b_reg;
    logic       last_a_reg;
    logic       last_b_reg;
    logic       run;
    logic       edge_a;
    logic       edge_b;
    logic       match_a;
    logic       match_b;
    logic       trig_ok;
    logic       trig_start;

    // true when the pin changed in the selected direction
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic now, input logic was);
        unique case (sel)
            tec_pkg::EDGE_FALL: edge_hit = was & ~now;
            tec_pkg::EDGE_RISE: edge_hit = ~was & now;
            tec_pkg::EDGE_NONE: edge_hit = 1'b0;
            tec_pkg::EDGE_BOTH: edge_hit = was ^ now;
        endcase
    endfunction : edge_hit

    // two flops on each pin before any logic reads it
    always_ff @(posedge clock) begin
        if (rst) begin
            sync_a_reg <= 2'h0;
            sync_b_reg <= 2'h0;
        end else begin
            sync_a_reg <= {sync_a_reg[0], trig_capture_in_a};
            sync_b_reg <= {sync_b_reg[0], capture_in_b};
        end
    end

    // previous levels; pins ignored while stopped
    always_ff @(posedge clock) begin
        if (rst) begin
            last_a_reg <= 1'b0;
            last_b_reg <= 1'b0;
        end else begin
            last_a_reg <= sync_a_reg[1];
            last_b_reg <= sync_b_reg[1];
        end
    end

    assign run    = (op_mode != tec_pkg::MODE_STOP);
    assign edge_a = run & edge_hit(edge_sel, sync_a_reg[1], last_a_reg);
    assign edge_b = run & edge_hit(edge_sel, sync_b_reg[1], last_b_reg);
    assign match_a = run & count_tick & (count_register == cap_cmp_reg_a);
    assign match_b = run & count_tick & (count_register == cap_cmp_reg_b);
    // one-shot only in free-running or trigger-clear mode
    assign trig_ok = oneshot_en & ((op_mode == tec_pkg::MODE_FREE) |
                     (op_mode == tec_pkg::MODE_CLR_TRG));
    // pin edge restarts even under software trigger, not mid-pulse
    assign trig_start = trig_ok & ~oneshot_busy &
                        (oneshot_sw_trigger | edge_a);

    ////////////////////////////////////////////////////////////////////////
    // counter
    // counts from the first tick after start; start phase may slip a tick
    always_ff @(posedge clock) begin
        if (rst || !run) begin
            count_register <= tec_pkg::CNT_RST;
        end else if (trig_start ||
                     (op_mode == tec_pkg::MODE_CLR_TRG && edge_a &&
                      !oneshot_busy)) begin
            count_register <= tec_pkg::CNT_RST;
        end else if (match_a && op_mode == tec_pkg::MODE_CLR_CMP) begin
            count_register <= tec_pkg::CNT_RST;
        end else if (count_tick) begin
            count_register <= count_register + tec_pkg::CNT_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture/compare registers; content is kept through stop
    always_ff @(posedge clock) begin
        if (rst) begin
            cap_cmp_reg_a <= tec_pkg::CMP_ZERO;
        end else if (capture_mode_a && edge_b) begin
            cap_cmp_reg_a <= count_register;
        end else if (cmp_a_we) begin
            cap_cmp_reg_a <= cmp_a_wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cap_cmp_reg_b <= tec_pkg::CMP_ZERO;
        end else if (capture_mode_b && edge_a) begin
            cap_cmp_reg_b <= count_register;
        end else if (cmp_b_we) begin
            cap_cmp_reg_b <= cmp_b_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // match pulses and one-shot output
    always_ff @(posedge clock) begin
        if (rst) begin
            match_a_irq <= 1'b0;
            match_b_irq <= 1'b0;
        end else begin
            match_a_irq <= match_a & ~capture_mode_a;
            match_b_irq <= match_b & ~capture_mode_b;
        end
    end

    // busy from trigger until a match ends the pulse
    always_ff @(posedge clock) begin
        if (rst || !run) begin
            oneshot_busy <= 1'b0;
        end else if (trig_start) begin
            oneshot_busy <= 1'b1;
        end else if (match_a) begin
            oneshot_busy <= 1'b0;
        end
    end

    // output rises at b match and falls at a match while busy
    always_ff @(posedge clock) begin
        if (rst || !run) begin
            timer_out <= 1'b0;
        end else if (oneshot_busy && match_a) begin
            timer_out <= 1'b0;
        end else if (oneshot_busy && match_b) begin
            timer_out <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    // stopping clears the count on the next edge
    a_stop_clears: assert property (
        @(posedge clock) disable iff (rst)
        !run |=> count_register == tec_pkg::CNT_RST)
        else $error("counter not cleared when stopped");
    a_count_live: assert property (
        @(posedge clock) disable iff (rst)
        run && count_tick && !trig_start && !edge_a && !match_a
        |=> count_register == $past(count_register) + tec_pkg::CNT_ONE)
        else $error("count did not advance");
    // an edge during a pulse lets the count run on untouched
    a_retrig_ignored: assert property (
        @(posedge clock) disable iff (rst)
        oneshot_busy && edge_a && !match_a && run && count_tick
        && op_mode == tec_pkg::MODE_FREE
        |=> count_register == $past(count_register) + tec_pkg::CNT_ONE)
        else $error("trigger restarted a running pulse");
    a_hw_trig_live: assert property (
        @(posedge clock) disable iff (rst)
        trig_ok && !oneshot_busy && edge_a |=> oneshot_busy)
        else $error("pin edge did not start a pulse");
    a_no_shot_cmp: assert property (
        @(posedge clock) disable iff (rst)
        op_mode == tec_pkg::MODE_CLR_CMP && !oneshot_busy
        |=> !oneshot_busy)
        else $error("one-shot started in compare-clear mode");
    a_out_rise: assert property (
        @(posedge clock) disable iff (rst)
        oneshot_busy && match_b && !match_a && run |=> timer_out)
        else $error("output missed b match");
    a_out_fall: assert property (
        @(posedge clock) disable iff (rst)
        oneshot_busy && match_a && run |=> !timer_out && !oneshot_busy)
        else $error("output missed a match");
    a_irq_pulse: assert property (
        @(posedge clock) disable iff (rst)
        match_a && !capture_mode_a |=> match_a_irq)
        else $error("missing match a pulse");
    a_irq_b_pulse: assert property (
        @(posedge clock) disable iff (rst)
        match_b && !capture_mode_b |=> match_b_irq)
        else $error("missing match b pulse");
    a_start_slip: assert property (
        @(posedge clock) disable iff (rst)
        $rose(run) |-> count_register == tec_pkg::CNT_RST)
        else $error("counter not at zero at start");
    // clear-on-compare mode restarts from zero at an a match
    a_cmp_restart: assert property (
        @(posedge clock) disable iff (rst)
        op_mode == tec_pkg::MODE_CLR_CMP && match_a
        |=> count_register == tec_pkg::CNT_RST)
        else $error("compare match did not restart the count");
    a_capture_b: assert property (
        @(posedge clock) disable iff (rst)
        capture_mode_b && edge_a |=> cap_cmp_reg_b == $past(count_register))
        else $error("pin a edge did not capture into b");
    // no pulse survives a stop
    a_stop_idle: assert property (
        @(posedge clock) disable iff (rst)
        !run |=> !oneshot_busy && !timer_out)
        else $error("pulse logic active while stopped");
endmodule : tec_timer
